// *** hdl/mie_exec_core.sv ***
// instruction executor: skips, calls, branches, clears, inc, or, watchdog
//
// Functional notes
// - bit clear skips next fetched instruction as no-op, two cycles
// - bit set skips next instruction, two cycles; no flag changes
// - direct call pushes pc+1, loads {high buffer bit0, address}
// - direct branch loads {high buffer bit0, address}, no push, two cycles
// - accumulator call pushes pc+1, loads {table pointer bit0, acc}
// - clear accumulator writes zero and sets zero flag, one cycle
// - watchdog clear zeroes counter, prescaler if assigned, sets power-down flag and timeout flag unless expiry coincides
// - clear register writes zero to addressed register, sets zero flag
// - complement register inverts operand, updates zero, goes to dest
// - interrupt disable clears global enable in one cycle
// - interrupt enable sets global enable in one cycle
// - increment register adds one with wrap, updates zero, to dest
// - increment skip writes dest, skips on zero result, no flags
// - software interrupt pushes pc+1, loads vector 001h, three cycles
// - register or merges accumulator and operand, updates zero, to dest
// - immediate or merges accumulator and constant into accumulator
// - destination bit zero selects accumulator, one selects the register
// - timeout flag high after reset or clear, low on watchdog expiry, which wins over a clear in the same cycle
`default_nettype none
module mie_exec_core
  import mie_pkg::*;
#(
  parameter int unsigned STACK_DEPTH = 4,
  parameter int unsigned NREG = 64,
  parameter int unsigned PSC_RATIO = 8,
  parameter int unsigned WDOG_LIMIT = 1000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic busy_o,
  output logic [8:0] pc_o,
  output logic zero_flag_o,
  output logic global_interrupt_enable_o,
  output logic timeout_flag_n_o,
  output logic powerdown_flag_n_o
);
  // --------------------------------------------------------------------
  // parameters and state
  // --------------------------------------------------------------------
  localparam int unsigned SPW = $clog2(STACK_DEPTH);
  localparam logic [7:0] PSC_LAST = 8'(PSC_RATIO - 1);
  localparam logic [15:0] WDOG_LAST = 16'(WDOG_LIMIT - 1);
  if (PSC_RATIO < 1 || PSC_RATIO > 256) begin : g_chk_psc
    $error("mie_exec_core: PSC_RATIO must lie in 1..256");
  end
  if (WDOG_LIMIT < 1 || WDOG_LIMIT > 65536) begin : g_chk_wdog
    $error("mie_exec_core: WDOG_LIMIT must lie in 1..65536");
  end
  typedef struct packed {
    mie_state_t st;
    logic busy;
    logic [1:0] wait_cnt;
    logic [15:0] instr;
    logic [7:0] acc;
    logic [8:0] pc;
    logic zero, global_interrupt_enable, to_n, pd_n, pchb, table_high_pointer, psc_wdog, wdog_en;
    logic [7:0] psc;
    logic [15:0] wdog;
    logic [5:0] rf_addr;
    logic ack;
    logic [31:0] dat;
  } mie_core_t;
  mie_core_t c_reg;
  mie_core_t c_next;
  // --------------------------------------------------------------------
  // decode of the bus request and the incoming instruction
  // --------------------------------------------------------------------
  logic wb_req, wb_wr, exec_go, dsel, psc_tick, wdog_tick, wdog_expire;
  logic [15:0] ins;
  mie_op_t op;
  logic [5:0] rsel, rf_raddr;
  logic [2:0] bsel;
  logic [7:0] imm, rf_rdata;
  logic [8:0] stk_top;
  logic [SPW-1:0] stk_level;
  mie_rfw_t rf_wr;
  mie_push_t push;
  // request is new while no ack is standing; writes need all lanes
  assign wb_req = wb_cyc_i & wb_stb_i & ~c_reg.ack;
  assign wb_wr = wb_req & wb_we_i & (wb_sel_i == 4'hf);
  assign exec_go = wb_wr & (wb_adr_i == ADR_INSTR) & (c_reg.st == MIE_IDLE);
  // operand fields of the instruction word
  assign ins = wb_dat_i[IW-1:0];
  assign op = mie_op_t'(ins[OPC_LSB +: OPC_W]);
  assign rsel = ins[REG_LSB +: REG_W];
  assign bsel = ins[BIT_LSB +: 3];
  assign dsel = ins[DEST_POS];
  assign imm = ins[IMM_LSB +: 8];
  assign rf_raddr = exec_go ? rsel : c_reg.rf_addr;
  // shared prescaler ticks; watchdog counts ticks or plain cycles
  assign psc_tick = (c_reg.psc == PSC_LAST);
  assign wdog_tick = c_reg.wdog_en & (c_reg.psc_wdog ? psc_tick : 1'b1);
  assign wdog_expire = wdog_tick & (c_reg.wdog == WDOG_LAST);
  // --------------------------------------------------------------------
  // storage blocks
  // --------------------------------------------------------------------
  mie_regfile #(.NREG(NREG)) u_regfile (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(rf_wr),
    .raddr_i(rf_raddr),
    .rdata_o(rf_rdata)
  );
  mie_stack #(.DEPTH(STACK_DEPTH)) u_stack (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(push),
    .top_o(stk_top),
    .level_o(stk_level)
  );
  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    logic [7:0] res;
    logic [1:0] cyc;
    logic wr_res;
    logic [8:0] pc_inc;
    logic [31:0] stat;
    res = RST_BYTE;
    cyc = CYC_ONE;
    wr_res = 1'b0;
    pc_inc = 9'(c_reg.pc + 9'h001);
    stat = '0;
    c_next = c_reg;
    rf_wr = '0;
    push = '0;
    c_next.ack = wb_req;
    // prescaler and watchdog counting
    c_next.psc = psc_tick ? RST_BYTE : 8'(c_reg.psc + 8'h01);
    c_next.wdog = wdog_tick ? 16'(c_reg.wdog + 16'h0001) : c_reg.wdog;
    // countdown of the extra cycles of a long instruction
    if (c_reg.st == MIE_EXEC) begin
      c_next.wait_cnt = 2'(c_reg.wait_cnt - 2'h1);
      c_next.st = (c_reg.wait_cnt == CYC_ONE) ? MIE_IDLE : MIE_EXEC;
    end
    // software register writes
    if (wb_wr) begin
      case (wb_adr_i)
        ADR_ACC: c_next.acc = wb_dat_i[7:0];
        ADR_PC: c_next.pc = wb_dat_i[8:0];
        ADR_PCHB: c_next.pchb = wb_dat_i[0];
        ADR_TABLE_HIGH_POINTER: c_next.table_high_pointer = wb_dat_i[0];
        ADR_CTRL: begin
          c_next.psc_wdog = wb_dat_i[CTRL_PSC_WDOG_BIT];
          c_next.wdog_en = wb_dat_i[CTRL_WDOG_EN_BIT];
        end
        ADR_RF_ADDR: c_next.rf_addr = wb_dat_i[5:0];
        ADR_RF_DATA: rf_wr = '{we: 1'b1, addr: c_reg.rf_addr, data: wb_dat_i[7:0]};
        default: ;
      endcase
    end
    // read data, unmapped addresses answer zero
    stat[ST_ZERO_BIT] = c_reg.zero;
    stat[ST_PD_BIT] = c_reg.pd_n;
    stat[ST_TO_BIT] = c_reg.to_n;
    stat[ST_GIE_BIT] = c_reg.global_interrupt_enable;
    stat[ST_BUSY_BIT] = c_reg.busy;
    c_next.dat = '0;
    if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        ADR_INSTR: c_next.dat = {16'h0000, c_reg.instr};
        ADR_ACC: c_next.dat = {24'h000000, c_reg.acc};
        ADR_PC: c_next.dat = {23'h000000, c_reg.pc};
        ADR_STATUS: c_next.dat = stat;
        ADR_PCHB: c_next.dat = {31'h00000000, c_reg.pchb};
        ADR_TABLE_HIGH_POINTER: c_next.dat = {31'h00000000, c_reg.table_high_pointer};
        ADR_CTRL: c_next.dat = {30'h00000000, c_reg.wdog_en, c_reg.psc_wdog};
        ADR_WDOG: c_next.dat = {16'h0000, c_reg.wdog};
        ADR_STACK: c_next.dat = {15'h0000, stk_top, 8'(stk_level)};
        ADR_RF_ADDR: c_next.dat = {26'h0000000, c_reg.rf_addr};
        ADR_RF_DATA: c_next.dat = {24'h000000, rf_rdata};
        default: c_next.dat = '0;
      endcase
    end
    // execute the written instruction
    if (exec_go) begin
      c_next.instr = ins;
      c_next.pc = pc_inc;
      case (op)
        OP_TEST_BIT_SKIP_IF_CLEAR: cyc = rf_rdata[bsel] ? CYC_ONE : CYC_TWO;
        OP_TEST_BIT_SKIP_IF_SET: cyc = rf_rdata[bsel] ? CYC_TWO : CYC_ONE;
        OP_DIRECT_CALL: begin
          push = '{push: 1'b1, addr: pc_inc};
          c_next.pc = {c_reg.pchb, imm};
          cyc = CYC_TWO;
        end
        OP_DIRECT_BRANCH: begin
          c_next.pc = {c_reg.pchb, imm};
          cyc = CYC_TWO;
        end
        OP_CALL_VIA_ACCUMULATOR: begin
          push = '{push: 1'b1, addr: pc_inc};
          c_next.pc = {c_reg.table_high_pointer, c_reg.acc};
          cyc = CYC_TWO;
        end
        OP_CLEAR_ACCUMULATOR: begin
          c_next.acc = RST_BYTE;
          c_next.zero = 1'b1;
        end
        OP_WATCHDOG_CLEAR: begin
          c_next.wdog = '0;
          c_next.psc = c_reg.psc_wdog ? RST_BYTE : c_next.psc;
          c_next.to_n = 1'b1;
          c_next.pd_n = 1'b1;
        end
        OP_CLEAR_REGISTER: begin
          rf_wr = '{we: 1'b1, addr: rsel, data: RST_BYTE};
          c_next.zero = 1'b1;
        end
        OP_COMPLEMENT_REGISTER: begin
          res = ~rf_rdata;
          wr_res = 1'b1;
          c_next.zero = (res == RST_BYTE);
        end
        OP_INTERRUPT_DISABLE: c_next.global_interrupt_enable = 1'b0;
        OP_INTERRUPT_ENABLE: c_next.global_interrupt_enable = 1'b1;
        OP_INCREMENT_REGISTER: begin
          res = 8'(rf_rdata + 8'h01);
          wr_res = 1'b1;
          c_next.zero = (res == RST_BYTE);
        end
        OP_INCREMENT_SKIP_ZERO: begin
          res = 8'(rf_rdata + 8'h01);
          wr_res = 1'b1;
          cyc = (res == RST_BYTE) ? CYC_TWO : CYC_ONE;
        end
        OP_SOFTWARE_INTERRUPT: begin
          push = '{push: 1'b1, addr: pc_inc};
          c_next.pc = SOFT_INT_VECTOR;
          cyc = CYC_THREE;
        end
        OP_OR_ACCUMULATOR_REGISTER: begin
          res = c_reg.acc | rf_rdata;
          wr_res = 1'b1;
          c_next.zero = (res == RST_BYTE);
        end
        OP_OR_ACCUMULATOR_IMMEDIATE: begin
          res = c_reg.acc | imm;
          c_next.acc = res;
          c_next.zero = (res == RST_BYTE);
        end
        default: ;
      endcase
      // a skip steps over the fetched word, which runs as a no-op
      if (cyc == CYC_TWO && op != OP_DIRECT_CALL && op != OP_DIRECT_BRANCH
          && op != OP_CALL_VIA_ACCUMULATOR) begin
        c_next.pc = 9'(c_reg.pc + 9'h002);
      end
      // destination select for results
      if (wr_res) begin
        if (dsel == DEST_ACC) begin
          c_next.acc = res;
        end else begin
          rf_wr = '{we: 1'b1, addr: rsel, data: res};
        end
      end
      c_next.wait_cnt = 2'(cyc - CYC_ONE);
      c_next.st = (cyc == CYC_ONE) ? MIE_IDLE : MIE_EXEC;
    end
    // expiry wins over a clear in the same cycle
    if (wdog_expire) begin
      c_next.wdog = '0;
      c_next.to_n = 1'b0;
    end
    c_next.busy = (c_next.st == MIE_EXEC);
  end
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c_reg <= '{st: MIE_IDLE, pc: RST_PC, to_n: 1'b1, pd_n: 1'b1, default: '0};
    end else begin
      c_reg <= c_next;
    end
  end
  // outputs straight from the state register
  assign wb_ack_o = c_reg.ack;
  assign wb_dat_o = c_reg.dat;
  assign busy_o = c_reg.busy;
  assign pc_o = c_reg.pc;
  assign zero_flag_o = c_reg.zero;
  assign global_interrupt_enable_o = c_reg.global_interrupt_enable;
  assign timeout_flag_n_o = c_reg.to_n;
  assign powerdown_flag_n_o = c_reg.pd_n;
  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence two_cyc_s;
    (c_reg.st == MIE_EXEC) ##1 (c_reg.st == MIE_IDLE);
  endsequence
  sequence three_cyc_s;
    (c_reg.st == MIE_EXEC) [*2] ##1 (c_reg.st == MIE_IDLE);
  endsequence
  skip_clear_a: assert property (
    exec_go && op == OP_TEST_BIT_SKIP_IF_CLEAR && !rf_rdata[bsel]
    |=> (c_reg.pc == 9'($past(c_reg.pc) + 9'h002)) ##0 two_cyc_s)
    else $error("skip on clear bit wrong");
  skip_set_a: assert property (
    exec_go && op == OP_TEST_BIT_SKIP_IF_SET
    |=> (c_reg.zero == $past(c_reg.zero))
    && (c_reg.busy == $past(rf_rdata[bsel])))
    else $error("skip on set bit wrong");
  call_direct_a: assert property (
    exec_go && op == OP_DIRECT_CALL
    |=> (c_reg.pc == {$past(c_reg.pchb), $past(imm)})
    && (stk_top == 9'($past(c_reg.pc) + 9'h001)) ##0 two_cyc_s)
    else $error("direct call wrong");
  branch_a: assert property (
    exec_go && op == OP_DIRECT_BRANCH
    |=> (c_reg.pc == {$past(c_reg.pchb), $past(imm)})
    && $stable(stk_level) ##0 two_cyc_s)
    else $error("direct branch wrong");
  call_acc_a: assert property (
    exec_go && op == OP_CALL_VIA_ACCUMULATOR
    |=> (c_reg.pc == {$past(c_reg.table_high_pointer), $past(c_reg.acc)})
    && (stk_top == 9'($past(c_reg.pc) + 9'h001)))
    else $error("accumulator call wrong");
  clear_acc_a: assert property (
    exec_go && op == OP_CLEAR_ACCUMULATOR
    |=> c_reg.acc == RST_BYTE && c_reg.zero && !c_reg.busy)
    else $error("accumulator clear wrong");
  wdog_clear_a: assert property (
    exec_go && op == OP_WATCHDOG_CLEAR && !wdog_expire
    |=> c_reg.to_n && c_reg.pd_n && c_reg.wdog == 16'h0000)
    else $error("watchdog clear wrong");
  clear_reg_a: assert property (
    exec_go && op == OP_CLEAR_REGISTER
    |-> rf_wr.we && rf_wr.data == RST_BYTE && rf_wr.addr == rsel ##1 c_reg.zero)
    else $error("register clear wrong");
  gie_a: assert property (
    exec_go && (op == OP_INTERRUPT_DISABLE || op == OP_INTERRUPT_ENABLE)
    |=> c_reg.global_interrupt_enable == ($past(op) == OP_INTERRUPT_ENABLE))
    else $error("global enable wrong");
  increment_register_acc_a: assert property (
    exec_go && op == OP_INCREMENT_REGISTER && dsel == DEST_ACC
    |=> c_reg.acc == 8'($past(rf_rdata) + 8'h01) && c_reg.zero == (c_reg.acc == 8'h00))
    else $error("increment to accumulator wrong");
  soft_int_a: assert property (
    exec_go && op == OP_SOFTWARE_INTERRUPT
    |=> (c_reg.pc == SOFT_INT_VECTOR) ##0 three_cyc_s)
    else $error("software interrupt wrong");
  or_imm_a: assert property (
    exec_go && op == OP_OR_ACCUMULATOR_IMMEDIATE
    |=> c_reg.acc == ($past(c_reg.acc) | $past(imm)))
    else $error("immediate or wrong");
  timeout_a: assert property (
    wdog_expire |=> !c_reg.to_n && c_reg.wdog == 16'h0000)
    else $error("watchdog timeout flag wrong");
endmodule
`default_nettype wire

// *** hdl/mie_pkg.sv ***
// package: opcodes, register map, field layout and carriers of the executor
`default_nettype none
package mie_pkg;
  // --------------------------------------------------------------------
  // instruction word layout
  // --------------------------------------------------------------------
  localparam int unsigned IW = 16;
  localparam int unsigned OPC_LSB = 11;
  localparam int unsigned OPC_W = 5;
  localparam int unsigned REG_LSB = 0;
  localparam int unsigned REG_W = 6;
  localparam int unsigned DEST_POS = 6;
  localparam int unsigned BIT_LSB = 7;
  localparam int unsigned IMM_LSB = 0;
  localparam logic DEST_ACC = 1'b0;
  // --------------------------------------------------------------------
  // register byte addresses
  // --------------------------------------------------------------------
  localparam logic [7:0] ADR_INSTR = 8'h00;
  localparam logic [7:0] ADR_ACC = 8'h04;
  localparam logic [7:0] ADR_PC = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0c;
  localparam logic [7:0] ADR_PCHB = 8'h10;
  localparam logic [7:0] ADR_TABLE_HIGH_POINTER = 8'h14;
  localparam logic [7:0] ADR_CTRL = 8'h18;
  localparam logic [7:0] ADR_WDOG = 8'h1c;
  localparam logic [7:0] ADR_STACK = 8'h20;
  localparam logic [7:0] ADR_RF_ADDR = 8'h24;
  localparam logic [7:0] ADR_RF_DATA = 8'h28;
  // --------------------------------------------------------------------
  // field positions, reset values, cycle counts
  // --------------------------------------------------------------------
  localparam int unsigned ST_ZERO_BIT = 0;
  localparam int unsigned ST_PD_BIT = 1;
  localparam int unsigned ST_TO_BIT = 2;
  localparam int unsigned ST_GIE_BIT = 3;
  localparam int unsigned ST_BUSY_BIT = 4;
  localparam int unsigned CTRL_PSC_WDOG_BIT = 0;
  localparam int unsigned CTRL_WDOG_EN_BIT = 1;
  localparam int unsigned STK_TOP_LSB = 8;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [8:0] RST_PC = 9'h000;
  localparam logic [8:0] SOFT_INT_VECTOR = 9'h001;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_TEST_BIT_SKIP_IF_CLEAR = 5'h01,
    OP_TEST_BIT_SKIP_IF_SET = 5'h02,
    OP_DIRECT_CALL = 5'h03,
    OP_DIRECT_BRANCH = 5'h04,
    OP_CALL_VIA_ACCUMULATOR = 5'h05,
    OP_CLEAR_ACCUMULATOR = 5'h06,
    OP_WATCHDOG_CLEAR = 5'h07,
    OP_CLEAR_REGISTER = 5'h08,
    OP_COMPLEMENT_REGISTER = 5'h09,
    OP_INTERRUPT_DISABLE = 5'h0a,
    OP_INTERRUPT_ENABLE = 5'h0b,
    OP_INCREMENT_REGISTER = 5'h0c,
    OP_INCREMENT_SKIP_ZERO = 5'h0d,
    OP_SOFTWARE_INTERRUPT = 5'h0e,
    OP_OR_ACCUMULATOR_REGISTER = 5'h0f,
    OP_OR_ACCUMULATOR_IMMEDIATE = 5'h10
  } mie_op_t;
  typedef enum logic [1:0] {
    MIE_IDLE = 2'b00,
    MIE_EXEC = 2'b01
  } mie_state_t;
  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [7:0] data;
  } mie_rfw_t;
  typedef struct packed {
    logic push;
    logic [8:0] addr;
  } mie_push_t;
endpackage
`default_nettype wire

// *** hdl/mie_regfile.sv ***
// register file of the core: one write port, one combinational read port
`default_nettype none
module mie_regfile
  import mie_pkg::*;
#(
  parameter int unsigned NREG = 64
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire mie_rfw_t wr_i,
  input wire logic [5:0] raddr_i,
  output logic [7:0] rdata_o
);
  if (NREG < 1 || NREG > 64) begin : g_chk
    $error("mie_regfile: NREG must lie in 1..64");
  end
  typedef struct packed {
    logic [NREG-1:0][7:0] mem;
  } mie_rf_state_t;
  mie_rf_state_t s_reg;
  mie_rf_state_t s_next;
  // write port, addresses beyond the file are dropped
  always_comb begin
    s_next = s_reg;
    if (wr_i.we && (32'(wr_i.addr) < NREG)) begin
      s_next.mem[wr_i.addr] = wr_i.data;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  // unimplemented addresses read as zero
  assign rdata_o = (32'(raddr_i) < NREG) ? s_reg.mem[raddr_i] : RST_BYTE;
endmodule
`default_nettype wire

// *** hdl/mie_stack.sv ***
// circular return stack: push only, top and level visible
`default_nettype none
module mie_stack
  import mie_pkg::*;
#(
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire mie_push_t push_i,
  output logic [8:0] top_o,
  output logic [$clog2(DEPTH)-1:0] level_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("mie_stack: DEPTH must be a power of two, at least 2");
  end
  typedef struct packed {
    logic [PW-1:0] ptr;
    logic [DEPTH-1:0][8:0] mem;
  } mie_stk_state_t;
  mie_stk_state_t s_reg;
  mie_stk_state_t s_next;
  // a push past the deepest level overwrites the oldest entry
  always_comb begin
    s_next = s_reg;
    if (push_i.push) begin
      s_next.mem[s_reg.ptr] = push_i.addr;
      s_next.ptr = PW'(s_reg.ptr + 1'b1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign top_o = s_reg.mem[PW'(s_reg.ptr - 1'b1)];
  assign level_o = s_reg.ptr;
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// testbench of the instruction executor: random and corner instructions
`default_nettype none
module tb
  import mie_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, b1, b2, m_z, m_gie, m_pchb, m_table_high_pointer;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00, m_acc, rv, res;
  logic [31:0] dat = 32'h0, rdat, v, wb_dat_o;
  logic [8:0] pc_o, m_pc, m_top;
  logic [7:0] m_rf [64];
  logic wb_ack_o, busy_o, zero_flag_o, gie_o, to_n_o, pd_n_o;
  int seed = int'(32'hcc77ce4e);
  int error_cnt = 0;
  int samples_checked = 0;

  mie_exec_core #(.WDOG_LIMIT(8)) i_mie_exec_core (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .busy_o(busy_o), .pc_o(pc_o), .zero_flag_o(zero_flag_o),
    .global_interrupt_enable_o(gie_o), .timeout_flag_n_o(to_n_o),
    .powerdown_flag_n_o(pd_n_o)
  );

  // clock of 100 ns
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // -------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one classic cycle; busy is sampled at the ack edge and the one after
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    b1 = busy_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    b2 = busy_o;
  endtask

  // run one instruction on the bench model, then compare the core with it
  task automatic ex(input logic [4:0] op, input logic [10:0] lo);
    logic [5:0] r;
    logic sk;
    logic [1:0] cy;
    r = lo[5:0];
    rv = m_rf[r];
    sk = 1'b0;
    cy = CYC_ONE;
    m_pc = m_pc + 9'h001;
    case (op)
      5'h01: sk = ~rv[lo[9:7]];
      5'h02: sk = rv[lo[9:7]];
      5'h03, 5'h04, 5'h05, 5'h0e: begin
        if (op != 5'h04) m_top = m_pc;
        m_pc = (op == 5'h05) ? {m_table_high_pointer, m_acc} :
          (op == 5'h0e) ? SOFT_INT_VECTOR : {m_pchb, lo[7:0]};
        cy = (op == 5'h0e) ? CYC_THREE : CYC_TWO;
      end
      5'h06, 5'h08: begin
        m_z = 1'b1;
        if (op == 5'h06) m_acc = 8'h00; else m_rf[r] = 8'h00;
      end
      5'h09, 5'h0c, 5'h0d, 5'h0f: begin
        res = (op == 5'h09) ? ~rv : (op == 5'h0f) ? (m_acc | rv) : rv + 8'h01;
        if (op != 5'h0d) m_z = (res == 8'h00);
        sk = (op == 5'h0d) && (res == 8'h00);
        if (lo[DEST_POS] == DEST_ACC) m_acc = res; else m_rf[r] = res;
      end
      5'h0a, 5'h0b: m_gie = op[0];
      5'h10: begin
        m_acc = m_acc | lo[7:0];
        m_z = (m_acc == 8'h00);
      end
      default: ;
    endcase
    if (sk) begin
      m_pc = m_pc + 9'h001;
      cy = CYC_TWO;
    end
    bus(1'b1, ADR_INSTR, {16'h0, op, lo});
    check(b1, cy > CYC_ONE);
    check(b2, cy > CYC_TWO);
    check(pc_o, m_pc);
    check(zero_flag_o, m_z);
    check(gie_o, m_gie);
    check({to_n_o, pd_n_o}, 2'b11);
    bus(1'b0, ADR_ACC, 32'h0);
    check(rdat, m_acc);
    bus(1'b0, ADR_STATUS, 32'h0);
    check(rdat[4:0], {1'b0, m_gie, 2'b11, m_z});
    bus(1'b0, ADR_STACK, 32'h0);
    check(rdat[16:8], m_top);
    bus(1'b1, ADR_RF_ADDR, {26'h0, r});
    bus(1'b0, ADR_RF_DATA, 32'h0);
    check(rdat, m_rf[r]);
  endtask

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    m_acc = 8'h00;
    m_pc = RST_PC;
    m_top = 9'h000;
    m_z = 1'b0;
    m_gie = 1'b0;
    m_rf = '{default: 8'h00};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 320; i++) begin
      v = $random(seed);
      m_acc = v[7:0];
      m_rf[v[25:20]] = (v[9:8] == 2'b00) ? 8'hff : v[17:10]; // wrap corner
      m_pchb = v[18];
      m_table_high_pointer = v[19];
      bus(1'b1, ADR_ACC, {24'h0, m_acc});
      bus(1'b1, ADR_RF_ADDR, {26'h0, v[25:20]});
      bus(1'b1, ADR_RF_DATA, {24'h0, m_rf[v[25:20]]});
      bus(1'b1, ADR_PCHB, {31'h0, m_pchb});
      bus(1'b1, ADR_TABLE_HIGH_POINTER, {31'h0, m_table_high_pointer});
      ex(5'(i % 18), v[30:20]); // opcodes 00 and 11 run as no-ops
    end
    $display("random instruction test done");
    bus(1'b1, ADR_CTRL, 32'h2);
    repeat (12) @(posedge clk_i);
    check(to_n_o, 1'b0);
    bus(1'b1, ADR_CTRL, 32'h0);
    ex(5'h07, 11'h000);
    bus(1'b0, ADR_WDOG, 32'h0);
    check(rdat, 32'h0);
    // watchdog fed by the prescaler needs about 64 cycles to expire
    bus(1'b1, ADR_CTRL, 32'h3);
    repeat (20) @(posedge clk_i);
    check(to_n_o, 1'b1);
    repeat (60) @(posedge clk_i);
    check(to_n_o, 1'b0);
    bus(1'b1, ADR_CTRL, 32'h0);
    bus(1'b0, 8'hfc, 32'h0);
    check(rdat, 32'h0);
    $display("watchdog and unmapped test done");
    stop_test();
  end

  // hang guard
  initial begin
    #(100 * 40000);
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
